// File: verilog/dmc_dma_controller.sv
`timescale 1ns/1ps
module dmc_dma_controller
	import dmc_pkg::*;
(
	// Clock and reset
	input  wire logic                           clock,
	input  wire logic                           rst,
	// Enables and triggers
	input  wire logic                           global_dma_cfg,
	input  wire logic [NUM_CH-1:0]              chan_enable_ctrl,
	input  wire logic [NUM_CH-1:0]              sw_trigger,
	input  wire logic [NUM_CH-1:0]              hw_trigger,
	// Channel setup
	input  wire logic [NUM_CH-1:0][ADDR_W-1:0]  chan_src_addr,
	input  wire logic [NUM_CH-1:0][ADDR_W-1:0]  chan_dst_addr,
	input  wire logic [NUM_CH-1:0][LEN_W-1:0]   block_len_minus1,
	input  wire logic [NUM_CH-1:0][LEN_W-1:0]   minus1_a,
	input  wire logic [NUM_CH-1:0][1:0]         trigger_mode_sel,
	input  wire logic [NUM_CH-1:0]              single_side_sel,
	input  wire logic [NUM_CH-1:0]              src_group_restart,
	input  wire logic [NUM_CH-1:0]              dst_group_restart,
	input  wire logic [NUM_CH-1:0][1:0]         src_addr_step,
	input  wire logic [NUM_CH-1:0][1:0]         dst_addr_step,
	input  wire logic [NUM_CH-1:0][2:0]         src_beat_width,
	input  wire logic [NUM_CH-1:0][2:0]         dst_beat_width,
	input  wire logic [NUM_CH-1:0][3:0]         bus_prot_ctrl,
	input  wire logic [NUM_CH-1:0]              src_byte_order,
	input  wire logic [NUM_CH-1:0]              dst_byte_order,
	input  wire logic [NUM_CH-1:0]              int_enable,
	// Status and interrupt
	input  wire logic [NUM_CH-1:0]              done_clear,
	output logic      [NUM_CH-1:0]              chan_running,
	output logic      [NUM_CH-1:0]              done_flag,
	output logic                                dma_irq,
	// Bus master
	output logic      [ADDR_W-1:0]              haddr,
	output logic      [1:0]                     htrans,
	output logic                                hwrite,
	output logic      [2:0]                     hsize,
	output logic      [2:0]                     hburst,
	output logic      [3:0]                     hprot,
	output logic                                hmastlock,
	output logic      [DATA_W-1:0]              hwdata,
	input  wire logic                           hready,
	input  wire logic                           hresp,
	input  wire logic [DATA_W-1:0]              hrdata
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [LEN_W:0] size_bytes(input logic [2:0] s);
		size_bytes = (s >= HSIZE_WORD) ? (LEN_W+1)'(4) : (LEN_W+1)'(1) << s[1:0];
	endfunction

	function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
			input logic [1:0] ctl, input logic [2:0] s);
		logic [ADDR_W-1:0] n;
		n = ADDR_W'(size_bytes(s));
		if (ctl[STEP_FIXED_BIT])
			step_addr = a;
		else if (ctl[STEP_DEC_BIT])
			step_addr = a - n;
		else
			step_addr = a + n;
	endfunction

	function automatic logic [DATA_W-1:0] swap(input logic [DATA_W-1:0] d,
			input logic en, input logic [2:0] s);
		swap = d;
		if (en && s == 3'h1)
			swap = {16'h0000, d[7:0], d[15:8]};
		else if (en && s >= HSIZE_WORD)
			swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
	endfunction

	function automatic logic [3:0] pick(input logic [NUM_CH-1:0] v);
		pick = 4'h0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (v[i])
				pick = 4'(i);
		end
	endfunction

	// ----------------------------------------
	// Trigger capture
	// ----------------------------------------
	logic [NUM_CH-1:0] trig_meta;
	logic [NUM_CH-1:0] trig_sync;
	logic [NUM_CH-1:0] trig_prev;
	logic [NUM_CH-1:0] pending;
	logic [NUM_CH-1:0] next_pending;
	logic [NUM_CH-1:0] served;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			trig_meta <= 16'h0000;
			trig_sync <= 16'h0000;
			trig_prev <= 16'h0000;
			pending   <= 16'h0000;
		end else begin
			trig_meta <= hw_trigger;
			trig_sync <= trig_meta;
			trig_prev <= trig_sync;
			pending   <= next_pending;
		end
	end

	// Hardware edge or software pulse; a new trigger wins over service
	always_comb begin
		next_pending = (pending & ~served) | (trig_sync & ~trig_prev) | sw_trigger;
		next_pending = next_pending & {NUM_CH{global_dma_cfg}} & chan_enable_ctrl;
	end

	// ----------------------------------------
	// Engine
	// ----------------------------------------
	dmc_state_type     state;
	dmc_state_type     next_state;
	logic [3:0]        ch;
	logic [3:0]        next_ch;
	logic [DATA_W-1:0] item;
	logic [DATA_W-1:0] next_item;
	logic [DATA_W-1:0] next_hwdata;
	logic [ADDR_W-1:0] cur_src [NUM_CH];
	logic [ADDR_W-1:0] cur_dst [NUM_CH];
	logic [LEN_W:0]    blk_cnt [NUM_CH];
	logic [LEN_W:0]    grp_cnt [NUM_CH];
	logic [ADDR_W-1:0] next_src [NUM_CH];
	logic [ADDR_W-1:0] next_dst [NUM_CH];
	logic [LEN_W:0]    next_blk [NUM_CH];
	logic [LEN_W:0]    next_grp [NUM_CH];
	logic [NUM_CH-1:0] finished;
	logic [NUM_CH-1:0] next_finished;
	logic [NUM_CH-1:0] next_done_flag;
	logic [NUM_CH-1:0] runnable;
	logic [LEN_W:0]    beat_n;
	logic [LEN_W:0]    blk_sum;
	logic [LEN_W:0]    grp_sum;
	logic              ended;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state     <= ST_IDLE;
			ch        <= 4'h0;
			item      <= 32'h00000000;
			hwdata    <= 32'h00000000;
			finished  <= 16'h0000;
			done_flag <= 16'h0000;
			for (int i = 0; i < NUM_CH; i++) begin
				cur_src[i] <= 32'h00000000;
				cur_dst[i] <= 32'h00000000;
				blk_cnt[i] <= 17'h00000;
				grp_cnt[i] <= 17'h00000;
			end
		end else begin
			state     <= next_state;
			ch        <= next_ch;
			item      <= next_item;
			hwdata    <= next_hwdata;
			finished  <= next_finished;
			done_flag <= next_done_flag;
			for (int i = 0; i < NUM_CH; i++) begin
				cur_src[i] <= next_src[i];
				cur_dst[i] <= next_dst[i];
				blk_cnt[i] <= next_blk[i];
				grp_cnt[i] <= next_grp[i];
			end
		end
	end

	always_comb begin
		runnable = {NUM_CH{global_dma_cfg}} & chan_enable_ctrl & ~finished;
		next_state     = state;
		next_ch        = ch;
		next_item      = item;
		next_hwdata    = hwdata;
		served         = 16'h0000;
		next_finished  = finished & chan_enable_ctrl;
		next_done_flag = done_flag & ~done_clear;
		ended          = 1'b0;
		for (int i = 0; i < NUM_CH; i++) begin
			next_src[i] = cur_src[i];
			next_dst[i] = cur_dst[i];
			next_blk[i] = blk_cnt[i];
			next_grp[i] = grp_cnt[i];
			if (!(global_dma_cfg && chan_enable_ctrl[i])) begin
				next_src[i] = chan_src_addr[i];
				next_dst[i] = chan_dst_addr[i];
				next_blk[i] = 17'h00000;
				next_grp[i] = 17'h00000;
			end
		end
		// Item size: single mode picks its side, otherwise the write size
		if (trigger_mode_sel[ch] == MODE_SINGLE && !single_side_sel[ch])
			beat_n = size_bytes(src_beat_width[ch]);
		else
			beat_n = size_bytes(dst_beat_width[ch]);
		blk_sum = blk_cnt[ch] + beat_n;
		grp_sum = grp_cnt[ch] + beat_n;
		unique case (state)
			ST_IDLE: begin
				if (|(pending & runnable)) begin
					next_ch = pick(pending & runnable);
					served[next_ch] = 1'b1;
					next_state = ST_RADDR;
				end
			end
			ST_RADDR: begin
				if (hready)
					next_state = ST_RDATA;
			end
			ST_RDATA: begin
				if (hready) begin
					next_item = swap(hrdata >> {cur_src[ch][1:0], 3'h0},
						src_byte_order[ch], src_beat_width[ch]);
					next_state = (hresp == HRESP_ERROR) ? ST_IDLE : ST_WADDR;
					ended = (hresp == HRESP_ERROR);
				end
			end
			ST_WADDR: begin
				if (hready) begin
					next_hwdata = swap(item, dst_byte_order[ch], dst_beat_width[ch])
						<< {cur_dst[ch][1:0], 3'h0};
					next_state = ST_WDATA;
				end
			end
			ST_WDATA: begin
				if (hready) begin
					next_state = ST_RADDR;
					next_src[ch] = step_addr(cur_src[ch], src_addr_step[ch],
						src_beat_width[ch]);
					next_dst[ch] = step_addr(cur_dst[ch], dst_addr_step[ch],
						dst_beat_width[ch]);
					next_blk[ch] = blk_sum;
					next_grp[ch] = grp_sum;
					if (hresp == HRESP_ERROR || blk_sum > {1'b0, block_len_minus1[ch]}) begin
						ended = 1'b1;
						next_state = ST_IDLE;
					end else if (trigger_mode_sel[ch] == MODE_GROUP &&
							grp_sum > {1'b0, minus1_a[ch]}) begin
						next_grp[ch] = 17'h00000;
						next_state = ST_IDLE;
						if (src_group_restart[ch])
							next_src[ch] = chan_src_addr[ch];
						if (dst_group_restart[ch])
							next_dst[ch] = chan_dst_addr[ch];
					end else if (trigger_mode_sel[ch] == MODE_SINGLE) begin
						next_state = ST_IDLE;
					end
				end
			end
		endcase
		if (ended) begin
			next_finished[ch] = 1'b1;
			next_blk[ch] = 17'h00000;
			next_grp[ch] = 17'h00000;
			next_src[ch] = chan_src_addr[ch];
			next_dst[ch] = chan_dst_addr[ch];
			if (int_enable[ch])
				next_done_flag[ch] = 1'b1;
		end
	end

	// ----------------------------------------
	// Status and interrupt
	// ----------------------------------------
	assign chan_running = runnable;
	assign dma_irq      = |done_flag;

	// ----------------------------------------
	// Bus master outputs
	// ----------------------------------------
	always_comb begin
		haddr     = 32'h00000000;
		htrans    = HTRANS_IDLE;
		hwrite    = 1'b0;
		hsize     = src_beat_width[ch];
		hburst    = HBURST_SINGLE;
		hmastlock = 1'b0;
		hprot     = HPROT_DEFAULT;
		if (bus_prot_ctrl[ch][PROT_EN_BIT])
			hprot = {bus_prot_ctrl[ch][2:0], 1'b1};
		if (state == ST_RADDR) begin
			haddr  = cur_src[ch];
			htrans = HTRANS_NONSEQ;
		end else if (state == ST_WADDR) begin
			haddr  = cur_dst[ch];
			htrans = HTRANS_NONSEQ;
			hwrite = 1'b1;
			hsize  = dst_beat_width[ch];
		end else if (state == ST_WDATA) begin
			hwrite = 1'b1;
			hsize  = dst_beat_width[ch];
		end
	end

endmodule

// File: verilog/dmc_pkg.sv
package dmc_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_CH = 16;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int LEN_W  = 16;
	// ----------------------------------------
	// Trigger modes and address stepping
	// ----------------------------------------
	localparam logic [1:0] MODE_SINGLE    = 2'h0;
	localparam logic [1:0] MODE_GROUP     = 2'h1;
	localparam logic [1:0] MODE_BLOCK     = 2'h2;
	localparam int         STEP_FIXED_BIT = 1;
	localparam int         STEP_DEC_BIT   = 0;
	// ----------------------------------------
	// Bus codes
	// ----------------------------------------
	localparam logic [1:0] HTRANS_IDLE   = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HBURST_SINGLE = 3'h0;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
	localparam logic       HRESP_ERROR   = 1'h1;
	localparam logic [3:0] HPROT_DEFAULT = 4'h3;
	localparam int         PROT_EN_BIT   = 3;
	// ----------------------------------------
	// Hardware trigger sources per channel
	// ----------------------------------------
	localparam int CH_ECG      = 15;
	localparam int CH_OPTICAL  = 14;
	localparam int CH_QFLASH   = 13;
	localparam int CH_TWI1     = 12;
	localparam int CH_TWI0     = 11;
	localparam int CH_AUDIO    = 10;
	localparam int CH_SER_LAST = 9;
	localparam int CH_SER_TX0  = 0;
	// ----------------------------------------
	// Engine states
	// ----------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_RADDR = 5'h02,
		ST_RDATA = 5'h04,
		ST_WADDR = 5'h08,
		ST_WDATA = 5'h10
	} dmc_state_type;
endpackage

// File: tb/dmc_monitor.sv
`timescale 1ns/1ps
module dmc_monitor
	import dmc_pkg::*;
(
	// Clock, reset, control
	input wire logic              clock,
	input wire logic              rst,
	input wire logic              global_dma_cfg,
	input wire logic [NUM_CH-1:0] chan_enable_ctrl,
	input wire logic [NUM_CH-1:0] int_enable,
	// Status
	input wire logic [NUM_CH-1:0] chan_running,
	input wire logic [NUM_CH-1:0] done_flag,
	input wire logic              dma_irq,
	// Bus master
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic [2:0]        hsize,
	input wire logic [2:0]        hburst,
	input wire logic              hmastlock,
	input wire logic              hready
);
	// ----
	// Checks
	// ----
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence rd_acc;
		htrans == HTRANS_NONSEQ && !hwrite && hready;
	endsequence
	sequence wr_req;
		htrans == HTRANS_NONSEQ && hwrite;
	endsequence
	a_burst_single: assert property (hburst == HBURST_SINGLE)
		else $error("burst not single");
	a_lock_low: assert property (!hmastlock)
		else $error("lock high");
	a_no_pipeline: assert property (htrans == HTRANS_NONSEQ && hready
		|=> htrans == HTRANS_IDLE)
		else $error("pipelined");
	a_read_then_write: assert property (rd_acc |-> ##[2:20] wr_req)
		else $error("read without write");
	a_irq_or: assert property (dma_irq == |done_flag)
		else $error("irq mismatch");
	a_run_gate: assert property (
		(chan_running & ~(chan_enable_ctrl & {NUM_CH{global_dma_cfg}})) == '0)
		else $error("runs ungated");
	a_flag_gate: assert property (
		(done_flag & ~$past(done_flag) & ~$past(int_enable)) == '0)
		else $error("flag without enable");
	a_size_legal: assert property (htrans == HTRANS_NONSEQ |-> hsize <= HSIZE_WORD)
		else $error("bad size");
	a_done_stops: assert property ((done_flag & ~$past(done_flag) & chan_running) == '0)
		else $error("done yet running");
endmodule
bind dmc_dma_controller dmc_monitor i_mon (.clock, .rst, .global_dma_cfg, .chan_enable_ctrl,
	.int_enable, .chan_running, .done_flag, .dma_irq, .htrans, .hwrite, .hsize, .hburst,
	.hmastlock, .hready);

// File: tb/dmc_mem_model.sv
`timescale 1ns/1ps
module dmc_mem_model
	import dmc_pkg::*;
(
	// Clock, reset, wait select
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              slow,
	// Bus slave
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [DATA_W-1:0] hwdata,
	output logic                   hready,
	output logic                   hresp,
	output logic      [DATA_W-1:0] hrdata
);
	// ----
	// Memory
	// ----
	logic [7:0]  mem [0:1023];
	logic        busy;
	logic        wr;
	logic [9:0]  a;
	logic [2:0]  sz;
	logic [31:0] rw;
	initial for (int k = 0; k < 1024; k++) mem[k] = 8'(k * 7 + 3);
	assign hresp = 1'b0;
	assign rw = {mem[{a[9:2], 2'h3}], mem[{a[9:2], 2'h2}], mem[{a[9:2], 2'h1}], mem[{a[9:2], 2'h0}]};
	// Idle read bus shows inverted data so stale values cannot pass
	assign hrdata = (busy && !wr && hready) ? rw : ~rw;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			hready <= 1'b1;
		end else if (!hready) begin
			hready <= 1'b1;
		end else begin
			if (busy && wr)
				for (int b = 0; b < (1 << sz); b++) mem[a + b] <= hwdata[8 * (a[1:0] + b) +: 8];
			busy <= htrans[1];
			wr <= hwrite;
			a <= haddr[9:0];
			sz <= hsize;
			hready <= !(htrans[1] && slow);
		end
	end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench import dmc_pkg::*;;
	logic                          clock, rst, global_dma_cfg, slow, hwrite, hmastlock;
	logic                          hready, hresp, dma_irq;
	logic [NUM_CH-1:0]             chan_enable_ctrl, sw_trigger, hw_trigger, single_side_sel;
	logic [NUM_CH-1:0]             src_group_restart, dst_group_restart, src_byte_order;
	logic [NUM_CH-1:0]             dst_byte_order, int_enable, done_clear, chan_running, done_flag;
	logic [NUM_CH-1:0][ADDR_W-1:0] chan_src_addr, chan_dst_addr;
	logic [NUM_CH-1:0][LEN_W-1:0]  block_len_minus1, minus1_a;
	logic [NUM_CH-1:0][1:0]        trigger_mode_sel, src_addr_step, dst_addr_step;
	logic [NUM_CH-1:0][2:0]        src_beat_width, dst_beat_width;
	logic [NUM_CH-1:0][3:0]        bus_prot_ctrl;
	logic [ADDR_W-1:0]             haddr;
	logic [DATA_W-1:0]             hwdata, hrdata;
	logic [2:0]                    hsize, hburst, last_size;
	logic [1:0]                    htrans;
	logic [3:0]                    hprot, last_prot;
	int                            fails = 0, total_checks = 0, beats = 0, seen;
	dmc_dma_controller i_dut (.clock, .rst, .global_dma_cfg, .chan_enable_ctrl, .sw_trigger,
		.hw_trigger, .chan_src_addr, .chan_dst_addr, .block_len_minus1, .minus1_a,
		.trigger_mode_sel, .single_side_sel, .src_group_restart, .dst_group_restart,
		.src_addr_step, .dst_addr_step, .src_beat_width, .dst_beat_width, .bus_prot_ctrl,
		.src_byte_order, .dst_byte_order, .int_enable, .done_clear, .chan_running, .done_flag,
		.dma_irq, .haddr, .htrans, .hwrite, .hsize, .hburst, .hprot, .hmastlock, .hwdata,
		.hready, .hresp, .hrdata);
	dmc_mem_model i_mem (.clock, .rst, .slow, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hresp, .hrdata);
	// ----
	// Helpers
	// ----
	always #2.5 clock = ~clock;
	always @(posedge clock) if (htrans === HTRANS_NONSEQ && hready === 1'b1) begin
		beats++;
		last_prot <= hprot;
		last_size <= hsize;
	end
	function automatic logic [7:0] sb(int k); return 8'(k * 7 + 3); endfunction
	function automatic logic [31:0] ew(int a);
		return {sb(a + 3), sb(a + 2), sb(a + 1), sb(a)};
	endfunction
	function automatic logic [31:0] mw(int a);
		return {i_mem.mem[a + 3], i_mem.mem[a + 2], i_mem.mem[a + 1], i_mem.mem[a]};
	endfunction
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic close_out;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic idle_wait;
		int n = 0;
		int q = 0;
		while (q < 12 && n < 800) begin
			@(posedge clock);
			#1;
			n++;
			q = (htrans === HTRANS_IDLE && hready === 1'b1) ? q + 1 : 0;
		end
		if (q < 12) begin
			fails++;
			$display("MISMATCH idle exp 12 got %0d", q);
			close_out();
		end
	endtask
	task automatic fire(int ch, bit hw);
		@(posedge clock);
		chan_enable_ctrl[ch] <= 1'b1;
		@(posedge clock);
		if (hw) hw_trigger[ch] <= 1'b1;
		else sw_trigger[ch] <= 1'b1;
		repeat (hw ? 4 : 1) @(posedge clock);
		hw_trigger[ch] <= 1'b0;
		sw_trigger[ch] <= 1'b0;
		idle_wait();
	endtask
	task automatic drop(int ch);
		@(posedge clock);
		chan_enable_ctrl[ch] <= 1'b0;
		done_clear[ch] <= 1'b1;
		@(posedge clock);
		done_clear[ch] <= 1'b0;
		#1;
		chk("clear", 32'h0, done_flag[ch]);
		@(posedge clock);
	endtask
	// ----
	// Scenarios
	// ----
	initial begin
		{clock, global_dma_cfg, slow, chan_enable_ctrl, sw_trigger, hw_trigger, single_side_sel,
			src_group_restart, dst_group_restart, src_byte_order, dst_byte_order, done_clear,
			chan_src_addr, chan_dst_addr, block_len_minus1, minus1_a, trigger_mode_sel,
			src_addr_step, dst_addr_step, bus_prot_ctrl} = '0;
		int_enable = '1;
		src_beat_width = {NUM_CH{3'h2}};
		dst_beat_width = {NUM_CH{3'h2}};
		rst = 1'b1;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		global_dma_cfg <= 1'b1;
		chan_src_addr[3] <= 32'h100;
		chan_dst_addr[3] <= 32'h200;
		block_len_minus1[3] <= 16'h7;
		trigger_mode_sel[3] <= MODE_BLOCK;
		fire(3, 0);
		chk("blk0", ew(32'h100), mw(32'h200));
		chk("blk1", ew(32'h104), mw(32'h204));
		chk("blk2", ew(32'h208), mw(32'h208));
		chk("bdone", 32'h1, done_flag[3]);
		chk("brun", 32'h0, chan_running[3]);
		chk("irq", 32'h1, dma_irq);
		chk("pdef", HPROT_DEFAULT, last_prot);
		drop(3);
		slow <= 1'b1;
		chan_src_addr[15] <= 32'h140;
		chan_dst_addr[15] <= 32'h240;
		block_len_minus1[15] <= 16'h7;
		minus1_a[15] <= 16'h3;
		trigger_mode_sel[15] <= MODE_GROUP;
		src_group_restart[15] <= 1'b1;
		fire(15, 1);
		chk("grp0", ew(32'h140), mw(32'h240));
		chk("grp1", ew(32'h244), mw(32'h244));
		chk("grun", 32'h1, chan_running[15]);
		fire(15, 1);
		chk("grp2", ew(32'h140), mw(32'h244));
		chk("gdone", 32'h1, done_flag[15]);
		drop(15);
		slow <= 1'b0;
		chan_src_addr[0] <= 32'h105;
		chan_dst_addr[0] <= 32'h300;
		block_len_minus1[0] <= 16'h1;
		src_addr_step[0] <= 2'h1;
		dst_addr_step[0] <= 2'h2;
		src_beat_width[0] <= 3'h0;
		dst_beat_width[0] <= 3'h0;
		int_enable[0] <= 1'b0;
		fire(0, 0);
		chk("sgl0", {sb(32'h303), sb(32'h302), sb(32'h301), sb(32'h105)}, mw(32'h300));
		chk("srun", 32'h1, chan_running[0]);
		fire(0, 0);
		chk("sgl1", {sb(32'h303), sb(32'h302), sb(32'h301), sb(32'h104)}, mw(32'h300));
		chk("ssize", 32'h0, last_size);
		chk("sflag", 32'h0, done_flag[0]);
		chk("send", 32'h0, chan_running[0]);
		drop(0);
		chan_src_addr[5] <= 32'h180;
		chan_dst_addr[5] <= 32'h280;
		block_len_minus1[5] <= 16'h3;
		trigger_mode_sel[5] <= MODE_BLOCK;
		src_byte_order[5] <= 1'b1;
		bus_prot_ctrl[5] <= 4'hE;
		fire(5, 0);
		chk("swap", {sb(32'h180), sb(32'h181), sb(32'h182), sb(32'h183)}, mw(32'h280));
		chk("prot", 32'hD, last_prot);
		drop(5);
		chan_src_addr[13] <= 32'h1C0;
		chan_dst_addr[13] <= 32'h2C0;
		block_len_minus1[13] <= 16'h7;
		minus1_a[13] <= 16'h3;
		trigger_mode_sel[13] <= MODE_GROUP;
		dst_group_restart[13] <= 1'b1;
		dst_byte_order[13] <= 1'b1;
		fire(13, 0);
		chk("dgrp0", {sb(32'h1C0), sb(32'h1C1), sb(32'h1C2), sb(32'h1C3)}, mw(32'h2C0));
		fire(13, 0);
		chk("dgrp1", {sb(32'h1C4), sb(32'h1C5), sb(32'h1C6), sb(32'h1C7)}, mw(32'h2C0));
		chk("dgrp2", ew(32'h2C4), mw(32'h2C4));
		chk("ddone", 32'h1, done_flag[13]);
		drop(13);
		chan_src_addr[1] <= 32'h110;
		chan_dst_addr[1] <= 32'h311;
		block_len_minus1[1] <= 16'h1;
		single_side_sel[1] <= 1'b1;
		src_addr_step[1] <= 2'h2;
		dst_addr_step[1] <= 2'h1;
		dst_beat_width[1] <= 3'h0;
		fire(1, 0);
		chk("side", 32'h1, chan_running[1]);
		fire(1, 0);
		chk("dsgl", {sb(32'h313), sb(32'h312), sb(32'h110), sb(32'h110)}, mw(32'h310));
		chk("dsize", 32'h0, last_size);
		chk("sdone", 32'h1, done_flag[1]);
		drop(1);
		global_dma_cfg <= 1'b0;
		trigger_mode_sel[2] <= MODE_BLOCK;
		seen = beats;
		fire(2, 0);
		chk("off", seen, beats);
		chk("orun", 32'h0, chan_running[2]);
		@(posedge clock);
		global_dma_cfg <= 1'b1;
		repeat (20) @(posedge clock);
		chk("late", seen, beats);
		close_out();
	end
endmodule
